/* src/sch_cfg.svh */
// Constants for the serial controller host port: register numbers, fields, counts.
// Assumes inclusion by every file that decodes registers or counts cycles.
`ifndef SCH_CFG_SVH
`define SCH_CFG_SVH
// ****************************************
// Register numbers inside a channel
// ****************************************
`define SCH_REG_CMD 4'h0
`define SCH_REG_MODE 4'h1
`define SCH_REG_VEC 4'h2
`define SCH_REG_PEND 4'h3
`define SCH_REG_MISC4 4'h4
`define SCH_REG_TXP 4'h5
`define SCH_REG_SYNC1 4'h6
`define SCH_REG_SYNC2 4'h7
`define SCH_REG_DATA 4'h8
`define SCH_REG_MIC 4'h9
`define SCH_REG_MSTAT 4'hA
`define SCH_REG_TCL 4'hC
`define SCH_REG_TCH 4'hD
`define SCH_REG_MCTL 4'hE
`define SCH_REG_EXT 4'hF
// ****************************************
// Field positions
// ****************************************
`define SCH_CMD_PTR_HI 3'h1
`define SCH_CMD_ERR_RST 3'h6
`define SCH_MODE_WR_EN 7
`define SCH_MODE_WR_FN 6
`define SCH_MODE_WR_RX 5
`define SCH_MODE_TX_IE 1
`define SCH_MODE_EXT_IE 0
`define SCH_TXP_DTR 7
`define SCH_TXP_TX_EN 3
`define SCH_MCTL_DTR_REQ 2
`define SCH_RST_HW 2'h3
`define SCH_RST_A 2'h2
`define SCH_RST_B 2'h1
`define SCH_SHIFT_LEFT 2'h2
`define SCH_RESET_VAL 8'h00
// ****************************************
// Depths and timing
// ****************************************
`define SCH_RX_FIFO_DEPTH 3
`define SCH_CLK_PERIOD_NS 10
`define SCH_RECOVERY_PCLK 4
`define SCH_STB_LOW_CYC 6
`define SCH_STB_HIGH_CYC 4
// ****************************************
// Host controller register offsets
// ****************************************
`define SCH_H_ADDR 2'h0
`define SCH_H_WDATA 2'h1
`define SCH_H_GO 2'h2
`define SCH_H_RDATA 2'h3
`endif

/* src/sch_pkg.sv */
// Types shared by both ends of the serial controller host port.
// Assumes nothing beyond a SystemVerilog compiler.
package sch_pkg;
    typedef enum logic [1:0] {SCH_ST_IDLE, SCH_ST_PTR, SCH_ST_ACC, SCH_ST_GAP} sch_hstate_t;
    typedef logic [7:0] sch_byte_t;
endpackage

/* src/sch_bus_if.sv */
// Parallel bus between the serial controller and its host.
// Assumes one clock; strobes are active low, data bus is resolved here.
`timescale 1ns/1ps
interface sch_bus_if;
    logic wr_n;
    logic rd_n;
    logic ce_n;
    logic a_b;
    logic d_c;
    logic as_n;
    logic [7:0] host_d;
    logic [7:0] dev_d;
    logic dev_oe;
    logic [7:0] ad;
    logic [1:0] w_req_n;
    logic [1:0] dtr_req_n;
    // Bus level: the device drives only while its read enable is up
    assign ad = dev_oe ? dev_d : host_d;
    modport dev (input wr_n, rd_n, ce_n, a_b, d_c, as_n, ad, output dev_d, dev_oe, w_req_n, dtr_req_n);
    modport host (output wr_n, rd_n, ce_n, a_b, d_c, as_n, host_d, input ad, w_req_n);
endinterface

/* src/sch_sync.sv */
// Two-flop synchroniser for one strobe level.
// Assumes an asynchronous input; reset value is the strobe's idle level.
`timescale 1ns/1ps
module sch_sync
(
    input wire logic clk, // Peripheral clock
    input wire logic reset, // Asynchronous reset
    input wire logic din, // Unsynchronised level
    output logic dout // Synchronised level
);
    logic meta_q;
    // Second flop only reads the first; idle high
    always_ff @(posedge clk or posedge reset)
    begin
        if (reset)
        begin
            meta_q <= 1'b1;
            dout <= 1'b1;
        end
        else
        begin
            meta_q <= din;
            dout <= meta_q;
        end
    end
endmodule

/* src/sch_dev.sv */
// Device end: register file, pointer access, receive queue, transmit buffer.
// Assumes host keeps recovery spacing and holds address and data through a strobe.
//
// The implementer's own choices: the register offsets and strobed register access.
`timescale 1ns/1ps
`include "sch_cfg.svh"
module sch_dev
    import sch_pkg::*;
#(
    parameter bit MUXED = 1'b0,
    parameter int FIFO_DEPTH = `SCH_RX_FIFO_DEPTH
)
(
    input wire logic clk, // Peripheral clock
    input wire logic reset, // Asynchronous reset
    sch_bus_if.dev bus, // Host bus
    input wire logic [1:0] rx_strobe, // Character done per channel, bit 0 is A
    input wire logic [1:0][7:0] rx_char, // Received character per channel
    input wire logic [1:0] tx_shift_empty, // Shifter wants a new load
    output logic [1:0] tx_load, // Shifter loaded this cycle
    output logic [1:0][19:0] tx_shift // Shift register contents
);
    logic wr_s, rd_s, wr_d_q, rd_d_q, wr_ev, rd_ev;
    logic [7:0] wr_q [2][16];
    logic [3:0] ptr_q [2];
    sch_byte_t fifo_q [2][FIFO_DEPTH];
    logic [1:0] cnt_q [2];
    sch_byte_t rsr_q [2];
    logic [1:0] rsr_full_q, ovr_q, tbuf_full_q;
    sch_byte_t tbuf_q [2];
    sch_byte_t dout_q;
    logic [5:0] alat_q;
    logic as_d_q;
    logic ch, reg_wr, reg_rd, pop, shift_left;
    logic [3:0] rsel;
    logic [5:0] pend;
    logic [2:0] vstat;
    sch_byte_t rdata;

    // ****************************************
    // Strobe synchronisation
    // ****************************************
    // strobe metastability guard
    sch_sync u_wr_sync (.clk(clk), .reset(reset), .din(bus.wr_n), .dout(wr_s));
    sch_sync u_rd_sync (.clk(clk), .reset(reset), .din(bus.rd_n), .dout(rd_s));

    // Edge detect on the synchronised levels only
    always_ff @(posedge clk or posedge reset)
    begin
        if (reset)
        begin
            wr_d_q <= 1'b1;
            rd_d_q <= 1'b1;
        end
        else
        begin
            wr_d_q <= wr_s;
            rd_d_q <= rd_s;
        end
    end
    assign wr_ev = wr_d_q & ~wr_s & ~bus.ce_n;
    assign rd_ev = rd_d_q & ~rd_s & ~bus.ce_n;

    // Multiplexed variant latches address at the strobe's rising edge
    always_ff @(posedge clk or posedge reset)
    begin
        if (reset)
        begin
            alat_q <= 6'h00;
            as_d_q <= 1'b1;
        end
        else
        begin
            as_d_q <= bus.as_n;
            if (bus.as_n & ~as_d_q)
                alat_q <= bus.ad[5:0];
        end
    end

    // ****************************************
    // Address decode
    // ****************************************
    // shift mode from channel B command
    assign shift_left = wr_q[1][`SCH_REG_CMD][1:0] == `SCH_SHIFT_LEFT;
    always_comb
    begin
        if (MUXED)
        begin
            ch = shift_left ? ~alat_q[5] : ~alat_q[0];
            // register from bits four to one
            rsel = alat_q[4:1];
        end
        else
        begin
            ch = ~bus.a_b;
            rsel = bus.d_c ? `SCH_REG_DATA : ptr_q[ch];
        end
    end
    assign reg_wr = wr_ev;
    assign reg_rd = rd_ev;
    assign pop = reg_rd & (rsel == `SCH_REG_DATA) & (cnt_q[ch] != 2'd0);

    // ****************************************
    // Register pointer
    // ****************************************
    always_ff @(posedge clk or posedge reset)
    begin
        if (reset)
        begin
            ptr_q[0] <= 4'h0;
            ptr_q[1] <= 4'h0;
        end
        else if (!MUXED && !bus.d_c && (reg_wr || reg_rd))
        begin
            if (reg_wr && ptr_q[ch] == `SCH_REG_CMD)
                ptr_q[ch] <= {bus.ad[5:3] == `SCH_CMD_PTR_HI, bus.ad[2:0]};
            else
                ptr_q[ch] <= 4'h0;
        end
    end

    // ****************************************
    // Write registers
    // ****************************************
    // per-channel write set; vector and master control shared in slot 0
    always_ff @(posedge clk or posedge reset)
    begin
        if (reset)
        begin
            for (int c = 0; c < 2; c++)
                for (int r = 0; r < 16; r++)
                    wr_q[c][r] <= `SCH_RESET_VAL;
        end
        else if (reg_wr)
        begin
            if (rsel == `SCH_REG_MIC && bus.ad[7:6] == `SCH_RST_HW)
            begin
                for (int c = 0; c < 2; c++)
                    for (int r = 0; r < 16; r++)
                        wr_q[c][r] <= `SCH_RESET_VAL;
            end
            else if (rsel == `SCH_REG_VEC || rsel == `SCH_REG_MIC)
                wr_q[0][rsel] <= bus.ad;
            else
                wr_q[ch][rsel] <= bus.ad;
        end
    end

    // ****************************************
    // Receive path
    // ****************************************
    // shift register then three-deep queue
    always_ff @(posedge clk or posedge reset)
    begin
        if (reset)
        begin
            for (int c = 0; c < 2; c++)
            begin
                rsr_q[c] <= 8'h00;
                cnt_q[c] <= 2'd0;
                for (int i = 0; i < FIFO_DEPTH; i++)
                    fifo_q[c][i] <= 8'h00;
            end
            rsr_full_q <= 2'b00;
            ovr_q <= 2'b00;
        end
        else
        begin
            for (int c = 0; c < 2; c++)
            begin
                logic pc;
                logic push;
                logic [1:0] base;
                pc = pop && (ch == c[0]);
                push = rsr_full_q[c] && (cnt_q[c] < 2'(FIFO_DEPTH) || pc);
                base = cnt_q[c] - {1'b0, pc};
                if (pc)
                    for (int i = 0; i < FIFO_DEPTH - 1; i++)
                        fifo_q[c][i] <= fifo_q[c][i + 1];
                if (push)
                    fifo_q[c][base] <= rsr_q[c];
                cnt_q[c] <= base + {1'b0, push};
                if (rx_strobe[c])
                begin
                    rsr_q[c] <= rx_char[c];
                    rsr_full_q[c] <= 1'b1;
                end
                else if (push)
                    rsr_full_q[c] <= 1'b0;
                // overrun grouped in special status; set beats error reset
                if (rx_strobe[c] && rsr_full_q[c] && !push)
                    ovr_q[c] <= 1'b1;
                else if (reg_wr && ch == c[0] && rsel == `SCH_REG_CMD && bus.ad[5:3] == `SCH_CMD_ERR_RST)
                    ovr_q[c] <= 1'b0;
            end
        end
    end

    // ****************************************
    // Transmit path
    // ****************************************
    // buffer or sync characters into shifter
    always_ff @(posedge clk or posedge reset)
    begin
        if (reset)
        begin
            tbuf_full_q <= 2'b00;
            tx_load <= 2'b00;
            for (int c = 0; c < 2; c++)
            begin
                tbuf_q[c] <= 8'h00;
                tx_shift[c] <= 20'h0_0000;
            end
        end
        else
        begin
            for (int c = 0; c < 2; c++)
            begin
                tx_load[c] <= 1'b0;
                if (tx_shift_empty[c] && tbuf_full_q[c])
                begin
                    tx_shift[c] <= {12'h000, tbuf_q[c]};
                    tx_load[c] <= 1'b1;
                end
                else if (tx_shift_empty[c] && wr_q[c][`SCH_REG_TXP][`SCH_TXP_TX_EN]
                         && wr_q[c][`SCH_REG_MISC4][3:2] == 2'b00)
                begin
                    // Sync modes idle with sync characters, no data
                    tx_shift[c] <= {4'h0, wr_q[c][`SCH_REG_SYNC2], wr_q[c][`SCH_REG_SYNC1]};
                    tx_load[c] <= 1'b1;
                end
                // New data wins over the drain in the same cycle
                if (reg_wr && ch == c[0] && rsel == `SCH_REG_DATA)
                begin
                    tbuf_q[c] <= bus.ad;
                    tbuf_full_q[c] <= 1'b1;
                end
                else if (tx_shift_empty[c])
                    tbuf_full_q[c] <= 1'b0;
            end
        end
    end

    // ****************************************
    // Interrupt pending and vector status
    // ****************************************
    // pending bits, A rx/tx/ext high
    always_comb
    begin
        for (int c = 0; c < 2; c++)
        begin
            pend[5 - 3 * c] = wr_q[c][`SCH_REG_MODE][4:3] != 2'b00 && cnt_q[c] != 2'd0;
            pend[4 - 3 * c] = wr_q[c][`SCH_REG_MODE][`SCH_MODE_TX_IE] & ~tbuf_full_q[c];
            pend[3 - 3 * c] = wr_q[c][`SCH_REG_MODE][`SCH_MODE_EXT_IE] & ovr_q[c];
        end
        casez (pend)
            6'b1?????: vstat = 3'h6;
            6'b01????: vstat = 3'h4;
            6'b001???: vstat = 3'h5;
            6'b0001??: vstat = 3'h2;
            6'b00001?: vstat = 3'h0;
            6'b000001: vstat = 3'h1;
            default: vstat = 3'h3;
        endcase
    end

    // ****************************************
    // Read registers
    // ****************************************
    // read map
    always_comb
    begin
        case (rsel)
            `SCH_REG_CMD: rdata = {5'h00, ~tbuf_full_q[ch], 1'b0, cnt_q[ch] != 2'd0};
            `SCH_REG_MODE: rdata = {2'b00, ovr_q[ch], 4'h0, ~tbuf_full_q[ch]};
            `SCH_REG_VEC: rdata = ch ? {wr_q[0][`SCH_REG_VEC][7:4], vstat, wr_q[0][`SCH_REG_VEC][0]}
                                     : wr_q[0][`SCH_REG_VEC];
            `SCH_REG_PEND: rdata = ch ? 8'h00 : {2'b00, pend};
            `SCH_REG_DATA: rdata = fifo_q[ch][0];
            `SCH_REG_MSTAT: rdata = 8'h00;
            `SCH_REG_TCL: rdata = wr_q[ch][`SCH_REG_TCL];
            `SCH_REG_TCH: rdata = wr_q[ch][`SCH_REG_TCH];
            `SCH_REG_EXT: rdata = wr_q[ch][`SCH_REG_EXT];
            default: rdata = 8'h00;
        endcase
    end

    // Read data captured at the detected strobe edge
    always_ff @(posedge clk or posedge reset)
    begin
        if (reset)
            dout_q <= 8'h00;
        else if (reg_rd)
            dout_q <= rdata;
    end
    assign bus.dev_d = dout_q;
    assign bus.dev_oe = ~bus.rd_n & ~bus.ce_n;

    // ****************************************
    // Wait/request and second request outputs
    // ****************************************
    always_comb
    begin
        for (int c = 0; c < 2; c++)
        begin
            logic rdy;
            rdy = wr_q[c][`SCH_REG_MODE][`SCH_MODE_WR_RX] ? (cnt_q[c] != 2'd0) : ~tbuf_full_q[c];
            // request when ready; wait when not
            bus.w_req_n[c] = ~(wr_q[c][`SCH_REG_MODE][`SCH_MODE_WR_EN]
                               & (wr_q[c][`SCH_REG_MODE][`SCH_MODE_WR_FN] ? rdy : ~rdy));
            bus.dtr_req_n[c] = wr_q[c][`SCH_REG_MCTL][`SCH_MCTL_DTR_REQ] ? tbuf_full_q[c]
                                                                        : ~wr_q[c][`SCH_REG_TXP][`SCH_TXP_DTR];
        end
    end
endmodule

/* src/sch_host.sv */
// Host end: turns register-port orders into pointer sequences on the bus.
// Assumes the device runs on the same clock and answers reads from flops.
`timescale 1ns/1ps
`include "sch_cfg.svh"
module sch_host
    import sch_pkg::*;
#(
    parameter int STB_LOW = `SCH_STB_LOW_CYC,
    parameter int STB_HIGH = `SCH_STB_HIGH_CYC
)
(
    input wire logic clk, // Peripheral clock
    input wire logic reset, // Asynchronous reset
    input wire logic [1:0] addr, // Register port address
    input wire logic [7:0] wdata, // Register port write data
    input wire logic wr, // Write strobe
    input wire logic rd, // Read strobe
    output logic [7:0] rdata, // Read data, cycle after rd
    sch_bus_if.host bus // Device bus
);
    sch_hstate_t st_q;
    logic [3:0] reg_q;
    logic chan_a_q, direct_q, read_q, ptr_phase_q;
    sch_byte_t wd_q, rd_q;
    logic [3:0] cnt_q;
    logic stb_q;
    logic stall;

    // ****************************************
    // Order registers
    // ****************************************
    always_ff @(posedge clk or posedge reset)
    begin
        if (reset)
        begin
            {read_q, direct_q, chan_a_q, reg_q} <= 7'h00;
            wd_q <= 8'h00;
        end
        else if (wr && st_q == SCH_ST_IDLE)
        begin
            if (addr == `SCH_H_ADDR)
                {read_q, direct_q, chan_a_q, reg_q} <= wdata[6:0];
            else if (addr == `SCH_H_WDATA)
                wd_q <= wdata;
        end
    end

    // Read port answers one cycle after the strobe
    always_ff @(posedge clk or posedge reset)
    begin
        if (reset)
            rdata <= 8'h00;
        else if (rd)
            rdata <= (addr == `SCH_H_GO) ? {7'h00, st_q != SCH_ST_IDLE}
                   : (addr == `SCH_H_RDATA) ? rd_q : 8'h00;
    end

    // stretch the strobe while wait is held
    // Wait counts only at the opening cycle of a data access. A write that fills the buffer can then never hold its own strobe
    // forever, but a request-mode pin low at that cycle still can; request mode belongs to DMA
    assign stall = ~bus.w_req_n[~chan_a_q] & ~ptr_phase_q & stb_q & (direct_q | (reg_q == `SCH_REG_DATA))
                   & (cnt_q == 4'(STB_LOW - 1));

    // ****************************************
    // Bus sequencer
    // ****************************************
    // low plus high spacing exceeds recovery
    always_ff @(posedge clk or posedge reset)
    begin
        if (reset)
        begin
            st_q <= SCH_ST_IDLE;
            cnt_q <= 4'h0;
            stb_q <= 1'b0;
            ptr_phase_q <= 1'b0;
            rd_q <= 8'h00;
        end
        else
        begin
            case (st_q)
                SCH_ST_IDLE:
                begin
                    if (wr && addr == `SCH_H_GO)
                    begin
                        ptr_phase_q <= ~direct_q && reg_q != `SCH_REG_CMD;
                        st_q <= SCH_ST_ACC;
                        stb_q <= 1'b1;
                        cnt_q <= 4'(STB_LOW - 1);
                    end
                end
                SCH_ST_ACC:
                begin
                    if (!stall)
                    begin
                        if (cnt_q != 4'h0)
                            cnt_q <= cnt_q - 4'h1;
                        else
                        begin
                            if (read_q && !ptr_phase_q)
                                rd_q <= bus.ad;
                            stb_q <= 1'b0;
                            cnt_q <= 4'(STB_HIGH - 1);
                            st_q <= ptr_phase_q ? SCH_ST_PTR : SCH_ST_GAP;
                        end
                    end
                end
                SCH_ST_PTR:
                begin
                    if (cnt_q != 4'h0)
                        cnt_q <= cnt_q - 4'h1;
                    else
                    begin
                        ptr_phase_q <= 1'b0;
                        stb_q <= 1'b1;
                        cnt_q <= 4'(STB_LOW - 1);
                        st_q <= SCH_ST_ACC;
                    end
                end
                SCH_ST_GAP:
                begin
                    if (cnt_q != 4'h0)
                        cnt_q <= cnt_q - 4'h1;
                    else
                        st_q <= SCH_ST_IDLE;
                end
                default: st_q <= SCH_ST_IDLE;
            endcase
        end
    end

    // Pins follow the sequencer
    assign bus.wr_n = ~(stb_q & (ptr_phase_q | ~read_q));
    assign bus.rd_n = ~(stb_q & ~ptr_phase_q & read_q);
    assign bus.ce_n = ~stb_q;
    assign bus.a_b = chan_a_q;
    assign bus.d_c = direct_q & ~ptr_phase_q;
    assign bus.as_n = 1'b1;
    assign bus.host_d = ptr_phase_q ? {1'b0, 1'b0, reg_q[3] ? `SCH_CMD_PTR_HI : 3'h0, reg_q[2:0]} : wd_q;
endmodule

/* sim/sch_bus_checker.sv */
// Concurrent checks on the parallel bus joining host and device ends.
// Assumes one clock and the interface signals wired in by name.
`timescale 1ns/1ps
module sch_bus_checker
(
    input wire logic clk, // Peripheral clock
    input wire logic reset, // Asynchronous reset
    input wire logic wr_n, // Write strobe
    input wire logic rd_n, // Read strobe
    input wire logic ce_n, // Chip enable
    input wire logic a_b, // Channel select
    input wire logic d_c, // Data select
    input wire logic [7:0] host_d, // Host data
    input wire logic dev_oe // Device drive enable
);
    // Either strobe low; recovery counts from any fall
    wire logic stb_n;
    assign stb_n = wr_n & rd_n;
    default clocking @(posedge clk); endclocking
    default disable iff (reset);
    oe_drive_a: assert property (dev_oe |-> !rd_n && !ce_n)
        else $error("device drives bus outside a read");
    no_clash_a: assert property (wr_n || rd_n)
        else $error("both strobes low together");
    fall_gap_a: assert property ($fell(stb_n) |=> !$fell(stb_n) [*3])
        else $error("strobe falls closer than recovery time");
    // Low time is a minimum only: a wait may stretch it
    stb_low_a: assert property ($fell(stb_n) |-> !stb_n [*6])
        else $error("strobe low time too short");
    stb_high_a: assert property ($rose(stb_n) |-> stb_n [*4])
        else $error("strobe high time too short");
    ce_cover_a: assert property (!stb_n |-> !ce_n)
        else $error("strobe without chip enable");
    dc_hold_a: assert property (!stb_n && !$past(stb_n) |-> $stable(d_c))
        else $error("data select moved in a strobe");
    ab_hold_a: assert property (!stb_n && !$past(stb_n) |-> $stable(a_b))
        else $error("channel select moved in a strobe");
    wd_hold_a: assert property (!wr_n && !$past(wr_n) |-> $stable(host_d))
        else $error("write data moved in a strobe");
endmodule

/* sim/tb_serial_controller_host_port.sv */
// Bench for host and device ends joined over the bus interface.
// Assumes the register port and the device side pins are driven here.
`timescale 1ns/1ps
`include "sch_cfg.svh"
module tb_serial_controller_host_port;
    import sch_pkg::*;
    logic clk = 0;
    logic reset = 1;
    logic [1:0] addr = '0;
    sch_byte_t wdata = '0;
    logic wr = 0;
    logic rd = 0;
    sch_byte_t rdata;
    logic [1:0] rx_strobe = '0;
    logic [1:0][7:0] rx_char = '0;
    logic [1:0] tx_shift_empty = '0;
    logic [1:0] tx_load;
    logic [1:0][19:0] tx_shift;
    int err_total = 0;
    int comparisons = 0;
    sch_byte_t got;
    sch_bus_if sch_bus_if_i ();
    sch_dev sch_dev_i (.clk(clk), .reset(reset), .bus(sch_bus_if_i.dev), .rx_strobe(rx_strobe),
        .rx_char(rx_char), .tx_shift_empty(tx_shift_empty), .tx_load(tx_load), .tx_shift(tx_shift));
    sch_host sch_host_i (.clk(clk), .reset(reset), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
        .rdata(rdata), .bus(sch_bus_if_i.host));
    sch_bus_checker sch_bus_checker_i (.clk(clk), .reset(reset), .wr_n(sch_bus_if_i.wr_n),
        .rd_n(sch_bus_if_i.rd_n), .ce_n(sch_bus_if_i.ce_n), .a_b(sch_bus_if_i.a_b),
        .d_c(sch_bus_if_i.d_c), .host_d(sch_bus_if_i.host_d), .dev_oe(sch_bus_if_i.dev_oe));
    // Free running clock, 10 ns period
    always #5 clk = ~clk;
    // Compare and count
    task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
        comparisons++;
        if (seen !== exp)
        begin
            err_total++;
            $display("[FAIL] %s expected %h seen %h", what, exp, seen);
        end
    endtask
    // Verdict and end of run
    task automatic stop_test();
        $display("comparisons %0d mismatches %0d", comparisons, err_total);
        if (err_total == 0 && comparisons > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask
    // One register port cycle; read data taken in the following cycle
    task automatic port(input logic [1:0] a, input sch_byte_t d, input logic is_rd);
        @(posedge clk);
        addr <= a;
        wdata <= d;
        wr <= !is_rd;
        rd <= is_rd;
        @(posedge clk);
        wr <= 1'b0;
        rd <= 1'b0;
        #1 got = rdata;
    endtask
    // Whole bus sequence: a = {read, direct, channel A, register}
    task automatic access(input logic [6:0] a, input sch_byte_t d);
        int n;
        port(`SCH_H_ADDR, {1'b0, a}, 1'b0);
        port(`SCH_H_WDATA, d, 1'b0);
        port(`SCH_H_GO, 8'h01, 1'b0);
        got = 8'h01;
        // Bounded poll so a stuck busy ends the run
        for (n = 0; n < 100 && got[0] !== 1'b0; n++)
            port(`SCH_H_GO, 8'h00, 1'b1);
        if (got[0] !== 1'b0)
        begin
            err_total++;
            stop_test();
        end
        if (a[6])
            port(`SCH_H_RDATA, 8'h00, 1'b1);
    endtask
    // Back to back pointer writes must each land, then read back per channel
    task automatic tc_readback();
        access({3'b001, `SCH_REG_TCL}, 8'h5A);
        access({3'b001, `SCH_REG_TCH}, 8'hA5);
        access({3'b000, `SCH_REG_TCL}, 8'h3C);
        access({3'b000, `SCH_REG_TCH}, 8'hC3);
        access({3'b101, `SCH_REG_TCL}, 8'h00);
        check("tc low a", got, 8'h5A);
        access({3'b101, `SCH_REG_TCH}, 8'h00);
        check("tc high a", got, 8'hA5);
        access({3'b100, `SCH_REG_TCL}, 8'h00);
        check("tc low b", got, 8'h3C);
        access({3'b100, `SCH_REG_TCH}, 8'h00);
        check("tc high b", got, 8'hC3);
    endtask
    // Vector written through B is the one vector seen unmodified through A, with status through B
    task automatic vec_shared();
        access({3'b000, `SCH_REG_VEC}, 8'h96);
        access({3'b101, `SCH_REG_VEC}, 8'h00);
        check("vector via a", got, 8'h96);
        // Channel B transmit interrupt on an empty buffer: status code 0 replaces bits 3 to 1
        access({3'b000, `SCH_REG_MODE}, 8'h02);
        access({3'b101, `SCH_REG_PEND}, 8'h00);
        check("pending via a", got, 8'h02);
        access({3'b100, `SCH_REG_VEC}, 8'h00);
        check("vector via b", got, 8'h90);
    endtask
    // Three queued characters, read direct, by pointer, then direct
    task automatic rx_queue();
        int i;
        for (i = 0; i < 3; i++)
        begin
            @(posedge clk);
            rx_char[0] <= 8'h40 + 8'(i);
            rx_strobe <= 2'b01;
            @(posedge clk);
            rx_strobe <= 2'b00;
        end
        access({3'b111, `SCH_REG_DATA}, 8'h00);
        check("rx first", got, 8'h40);
        access({3'b101, `SCH_REG_DATA}, 8'h00);
        check("rx second", got, 8'h41);
        access({3'b111, `SCH_REG_DATA}, 8'h00);
        check("rx third", got, 8'h42);
    endtask
    // Modes, then interrupt mode, then enable; wait and request follow the buffer
    task automatic tx_handshake();
        int n;
        access({3'b001, `SCH_REG_MISC4}, 8'h44);
        access({3'b001, `SCH_REG_MODE}, 8'h80);
        access({3'b001, `SCH_REG_TXP}, 8'h08);
        check("wait idle", sch_bus_if_i.w_req_n[0], 1'b1);
        access({3'b011, `SCH_REG_DATA}, 8'hE7);
        check("wait full", sch_bus_if_i.w_req_n[0], 1'b0);
        @(posedge clk);
        tx_shift_empty <= 2'b01;
        for (n = 0; n < 20 && tx_load[0] !== 1'b1; n++)
            @(posedge clk);
        check("tx load", tx_load[0], 1'b1);
        check("tx shift", tx_shift[0][7:0], 8'hE7);
        tx_shift_empty <= 2'b00;
        repeat (2) @(posedge clk);
        check("wait emptied", sch_bus_if_i.w_req_n[0], 1'b1);
        access({3'b001, `SCH_REG_MODE}, 8'hC0);
        check("request a", sch_bus_if_i.w_req_n, 2'b10);
        access({3'b001, `SCH_REG_MCTL}, 8'h04);
        check("second request", sch_bus_if_i.dtr_req_n[0], 1'b0);
    endtask
    // Mid-run reset with a pointer left aimed; the next pointer sequence must still find its register
    task automatic reset_clear();
        // A bare command write leaves channel A pointing at the low time constant
        access({3'b001, `SCH_REG_CMD}, 8'h0C);
        @(posedge clk);
        reset <= 1'b1;
        repeat (2) @(posedge clk);
        reset <= 1'b0;
        access({3'b101, `SCH_REG_TCL}, 8'h00);
        check("tc after reset", got, `SCH_RESET_VAL);
    endtask
    // Main sequence after four cycles of reset
    initial
    begin
        repeat (4) @(posedge clk);
        reset <= 1'b0;
        tc_readback();
        vec_shared();
        rx_queue();
        tx_handshake();
        reset_clear();
        stop_test();
    end
endmodule
